// File: rtl/irf_pkg.sv
// constants of the interrupt request flag registers
//------------------------------------------------------------
//------------------------------------------------------------
package irf_pkg;
    // byte addresses in the special function register space
    localparam logic [7:0] EXT_FLAGS_ADDR = 8'hd8;
    localparam logic [7:0] RADIO_FLAGS_ADDR = 8'he8;
    localparam logic [7:0] TIMER_FLAGS_ADDR = 8'hf8;
    // bit address: upper five bits pick the register, low three the bit
    localparam int BIT_SEL_W = 3;
    // writable bits of each register
    localparam logic [7:0] EXT_WRITE_MASK = 8'h03;
    localparam logic [7:0] RADIO_WRITE_MASK = 8'hff;
    localparam logic [7:0] TIMER_WRITE_MASK = 8'hff;
    // value after reset
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // field positions
    localparam int EXT_PIN_A_BIT = 0;
    localparam int EXT_PIN_B_BIT = 1;
    localparam int SYNTH_LOCK_BIT = 0;
    localparam int TX_FIFO_BIT = 1;
    localparam int RX_FIFO_BIT = 2;
    localparam int SERIAL_READY_BIT = 4;
    localparam int NOISE_RATIO_BIT = 5;
    localparam int SIGNALING_WORD_BIT = 6;
    localparam int WATCHDOG_BIT = 0;
    localparam int SUPPLY_DROP_BIT = 1;
    localparam int CAPTURE_B_BIT = 4;
    localparam int CAPTURE_A_BIT = 5;
    localparam int TIME_BASE_BIT = 6;
endpackage : irf_pkg

// File: rtl/irf_request_flags.sv
// three bit-addressable interrupt request flag registers
`timescale 1ns/1ns
module irf_request_flags
    import irf_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    // special function register port of the cpu core
    input wire logic [7:0] sfrAddr, // byte address or bit address
    input wire logic sfrWrite, // byte write strobe
    input wire logic sfrBitWrite, // bit write strobe, sfrAddr is a bit address
    input wire logic [7:0] sfrWdata, // byte write data
    input wire logic sfrBitWdata, // bit write value
    output logic [7:0] sfrRdata, // byte read data, 0 when unmapped
    output logic sfrRbit, // bit read value at sfrAddr as bit address
    output logic sfrHit, // address hits one of the registers
    // one-cycle hardware set events
    input wire logic extPinAEvent, // detected event on ext_pin_a
    input wire logic extPinBEvent, // detected event on ext_pin_b
    input wire logic signalingWordEvent, // signaling word detected
    input wire logic noiseRatioEvent, // s/n ratio detected
    input wire logic serialReadyEvent, // serial data ready
    input wire logic rxFifoLevelEvent, // receive fifo threshold
    input wire logic txFifoLevelEvent, // transmit fifo threshold
    input wire logic synthLockEvent, // lock detected
    input wire logic timeBaseEvent, // time base overflow
    input wire logic captureTimerAEvent, // capture timer 1 overflow
    input wire logic captureTimerBEvent, // capture timer 2 overflow
    input wire logic supplyDropEvent, // supply level detected
    input wire logic watchdogEvent, // watchdog overflow
    // enables held elsewhere
    input wire logic [7:0] extSourceEnable, // per-source enables, external
    input wire logic [7:0] radioSourceEnable, // per-source enables, radio
    input wire logic [7:0] timerSourceEnable, // per-source enables, timer
    input wire logic [2:0] groupEnable, // group enable per register
    input wire logic globalEnable, // global enable
    // flags and requests
    output logic [7:0] externalRequestFlags, // external register contents
    output logic [7:0] radioRequestFlags, // radio register contents
    output logic [7:0] timerRequestFlags, // timer register contents
    output logic irqRequest // any enabled flag pending
);
    import irf_pkg::*;

    //------------------------------------------------------------
    // register state
    //------------------------------------------------------------
    // source masks: reserved bits have no source behind them, so they never request
    localparam logic [7:0] RADIO_SOURCE_MASK = 8'h77; // word, ratio, serial, rx, tx, lock
    localparam logic [7:0] TIMER_SOURCE_MASK = 8'h73; // time base, captures, supply, watchdog
    logic [7:0] ext_reg; // external flags, flop output of its instance
    logic [7:0] radio_reg; // radio flags, flop output of its instance
    logic [7:0] timer_reg; // timer flags, flop output of its instance
    logic extPending; // an enabled external flag is set
    logic radioPending; // an enabled radio flag is set
    logic timerPending; // an enabled timer flag is set
    logic [7:0] extSet, radioSet, timerSet; // hardware set vectors
    logic [7:0] bitOneHot; // bit selected by a bit address
    logic [7:0] regBase; // register base picked by a bit address

    //------------------------------------------------------------
    // hardware set vectors
    //------------------------------------------------------------
    always_comb begin
        extSet = 8'h00;
        extSet[EXT_PIN_A_BIT] = extPinAEvent;
        extSet[EXT_PIN_B_BIT] = extPinBEvent;
        radioSet = 8'h00;
        radioSet[SIGNALING_WORD_BIT] = signalingWordEvent;
        radioSet[NOISE_RATIO_BIT] = noiseRatioEvent;
        radioSet[SERIAL_READY_BIT] = serialReadyEvent;
        radioSet[RX_FIFO_BIT] = rxFifoLevelEvent;
        radioSet[TX_FIFO_BIT] = txFifoLevelEvent;
        radioSet[SYNTH_LOCK_BIT] = synthLockEvent;
        timerSet = 8'h00;
        timerSet[TIME_BASE_BIT] = timeBaseEvent;
        timerSet[CAPTURE_A_BIT] = captureTimerAEvent;
        timerSet[CAPTURE_B_BIT] = captureTimerBEvent;
        timerSet[SUPPLY_DROP_BIT] = supplyDropEvent;
        timerSet[WATCHDOG_BIT] = watchdogEvent;
    end

    //------------------------------------------------------------
    // bit address decode: base is the address with low bits cleared
    //------------------------------------------------------------
    always_comb begin
        regBase = {sfrAddr[7:BIT_SEL_W], {BIT_SEL_W{1'b0}}};
        bitOneHot = 8'h01 << sfrAddr[BIT_SEL_W-1:0];
    end

    //------------------------------------------------------------
    // flag registers: one instance per register, each with its own write
    // decode, so the three can never disagree on write priority
    //------------------------------------------------------------
    // external register: only the two pin flags exist
    irf_flag_byte #(
        .BASE_ADDR(EXT_FLAGS_ADDR),
        .WRITE_MASK(EXT_WRITE_MASK)
    ) u_irf_flag_byte_ext (
        .clk(clk),
        .sys_rst(sys_rst),
        .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite),
        .sfrBitWrite(sfrBitWrite),
        .sfrWdata(sfrWdata),
        .sfrBitWdata(sfrBitWdata),
        .hwSet(extSet),
        .flags(ext_reg)
    );

    // radio register: reserved bits stay writable
    irf_flag_byte #(
        .BASE_ADDR(RADIO_FLAGS_ADDR),
        .WRITE_MASK(RADIO_WRITE_MASK)
    ) u_irf_flag_byte_radio (
        .clk(clk),
        .sys_rst(sys_rst),
        .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite),
        .sfrBitWrite(sfrBitWrite),
        .sfrWdata(sfrWdata),
        .sfrBitWdata(sfrBitWdata),
        .hwSet(radioSet),
        .flags(radio_reg)
    );

    // timer register: reserved bits stay writable
    irf_flag_byte #(
        .BASE_ADDR(TIMER_FLAGS_ADDR),
        .WRITE_MASK(TIMER_WRITE_MASK)
    ) u_irf_flag_byte_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite),
        .sfrBitWrite(sfrBitWrite),
        .sfrWdata(sfrWdata),
        .sfrBitWdata(sfrBitWdata),
        .hwSet(timerSet),
        .flags(timer_reg)
    );

    //------------------------------------------------------------
    // read path: combinational so the core sees data in its cycle
    //------------------------------------------------------------
    always_comb begin
        sfrHit = 1'b1;
        case (sfrAddr)
            EXT_FLAGS_ADDR: sfrRdata = ext_reg;
            RADIO_FLAGS_ADDR: sfrRdata = radio_reg;
            TIMER_FLAGS_ADDR: sfrRdata = timer_reg;
            default: begin
                sfrRdata = 8'h00; // unmapped reads zero
                sfrHit = 1'b0;
            end
        endcase
        case (regBase)
            EXT_FLAGS_ADDR: sfrRbit = |(ext_reg & bitOneHot);
            RADIO_FLAGS_ADDR: sfrRbit = |(radio_reg & bitOneHot);
            TIMER_FLAGS_ADDR: sfrRbit = |(timer_reg & bitOneHot);
            default: sfrRbit = 1'b0;
        endcase
    end

    //------------------------------------------------------------
    // outputs; reserved flags carry no source enable, so never request
    //------------------------------------------------------------
    assign externalRequestFlags = ext_reg;
    assign radioRequestFlags = radio_reg;
    assign timerRequestFlags = timer_reg;

    // per group: a flag must be set and its own source enabled
    always_comb begin
        extPending = |(ext_reg & extSourceEnable & EXT_WRITE_MASK);
        radioPending = |(radio_reg & radioSourceEnable & RADIO_SOURCE_MASK);
        timerPending = |(timer_reg & timerSourceEnable & TIMER_SOURCE_MASK);
    end

    // the global enable gates all groups at once
    assign irqRequest = globalEnable & (
        (groupEnable[0] & extPending) |
        (groupEnable[1] & radioPending) |
        (groupEnable[2] & timerPending));
endmodule : irf_request_flags

//------------------------------------------------------------
// one bit-addressable flag register
//------------------------------------------------------------
module irf_flag_byte
    import irf_pkg::*;
#(
    parameter logic [7:0] BASE_ADDR = EXT_FLAGS_ADDR, // byte address, low three bits zero
    parameter logic [7:0] WRITE_MASK = EXT_WRITE_MASK // bits that exist and software may change
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [7:0] sfrAddr, // byte address or bit address
    input wire logic sfrWrite, // byte write strobe
    input wire logic sfrBitWrite, // bit write strobe
    input wire logic [7:0] sfrWdata, // byte write data
    input wire logic sfrBitWdata, // bit write value
    input wire logic [7:0] hwSet, // hardware set pulses by bit position
    output logic [7:0] flags // register contents
);
    import irf_pkg::*;

    logic [7:0] flags_reg; // flag bits
    logic [7:0] flags_next; // value for the next edge
    logic [7:0] swValue; // value after the software access alone
    logic byteHit; // byte write aimed at this register
    logic bitHit; // bit write aimed at this register
    logic [7:0] bitOneHot; // bit picked by the low address bits

    //------------------------------------------------------------
    // address decode
    //------------------------------------------------------------
    always_comb begin
        byteHit = sfrWrite && (sfrAddr == BASE_ADDR);
        // a byte write in the same cycle wins, so a bit write is dropped then
        bitHit = sfrBitWrite && !sfrWrite && (sfrAddr[7:BIT_SEL_W] == BASE_ADDR[7:BIT_SEL_W]);
        bitOneHot = 8'h01 << sfrAddr[BIT_SEL_W-1:0];
    end

    //------------------------------------------------------------
    // next value: software access first, hardware sets on top,
    // so an event in the cycle of a clear is never lost
    //------------------------------------------------------------
    always_comb begin
        swValue = flags_reg;
        if (byteHit) begin
            swValue = (flags_reg & ~WRITE_MASK) | (sfrWdata & WRITE_MASK);
        end else if (bitHit) begin
            if (sfrBitWdata) begin
                swValue = flags_reg | (bitOneHot & WRITE_MASK);
            end else begin
                swValue = flags_reg & ~(bitOneHot & WRITE_MASK);
            end
        end
        // missing bits never hold a one, even if a set vector names them
        flags_next = (swValue | hwSet) & WRITE_MASK;
    end

    //------------------------------------------------------------
    // flag state, cleared by reset
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg; // flop output straight to the port
endmodule : irf_flag_byte

// File: dv/irf_event_model.sv
// peripheral event sources for the flag registers
`timescale 1ns/1ns
module irf_event_model (
    input wire logic clk, // system clock
    input wire logic [23:0] fire, // events asked for, by flag position
    output logic [23:0] evt // event pulses, launched off the falling edge
);
    logic [23:0] pend_reg; // request seen at the rising edge
    always @(posedge clk) pend_reg <= fire;
    always @(negedge clk) evt <= pend_reg;
endmodule : irf_event_model

// File: dv/irf_request_flags_assertions.sv
// concurrent checks on the request flag register ports
`timescale 1ns/1ns
module irf_request_flags_assertions (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [7:0] sfrAddr, // byte or bit address
    input wire logic sfrWrite, // byte write strobe
    input wire logic sfrBitWrite, // bit write strobe
    input wire logic [7:0] sfrWdata, // byte write data
    input wire logic sfrBitWdata, // bit write value
    input wire logic [7:0] sfrRdata, // byte read data
    input wire logic sfrRbit, // bit read value
    input wire logic sfrHit, // address hits a register
    input wire logic extPinBEvent, // pin b event
    input wire logic txFifoLevelEvent, // transmit fifo threshold
    input wire logic watchdogEvent, // watchdog overflow
    input wire logic globalEnable, // global enable
    input wire logic irqRequest, // combined request
    input wire logic [7:0] externalRequestFlags, // external flags
    input wire logic [7:0] radioRequestFlags, // radio flags
    input wire logic [7:0] timerRequestFlags // timer flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_ext_spare: assert property (externalRequestFlags[7:2] == 6'h00) else $error("ext spare set");
    chk_reset_zero: assert property (disable iff (1'h0) sys_rst |=> !{externalRequestFlags, radioRequestFlags,
        timerRequestFlags}) else $error("flags not reset");
    chk_hw_wins: assert property (txFifoLevelEvent && sfrWrite && sfrAddr == 8'he8 |=> radioRequestFlags[1])
        else $error("tx event lost");
    chk_byte_set: assert property (sfrWrite && sfrAddr == 8'hf8 |=>
        (timerRequestFlags & $past(sfrWdata)) == $past(sfrWdata)) else $error("byte write lost");
    chk_bit_set: assert property (sfrBitWrite && !sfrWrite && sfrBitWdata && sfrAddr[7:3] == 5'h1d |=>
        radioRequestFlags[$past(sfrAddr[2:0])]) else $error("bit write lost");
    chk_bit_read: assert property (sfrAddr[7:3] == 5'h1f |-> sfrRbit == timerRequestFlags[sfrAddr[2:0]])
        else $error("bit read wrong");
    chk_read_mux: assert property (sfrAddr == 8'hf8 |-> sfrHit && sfrRdata == timerRequestFlags)
        else $error("byte read wrong");
    chk_irq_gate: assert property (!globalEnable |-> !irqRequest) else $error("irq without global");
    chk_pin_sets: assert property (extPinBEvent |=> externalRequestFlags[1])
        else $error("pin flag lost");
    chk_watchdog_sets: assert property (watchdogEvent |=> timerRequestFlags[0])
        else $error("watchdog flag lost");
endmodule : irf_request_flags_assertions
bind irf_request_flags irf_request_flags_assertions u_irf_request_flags_assertions (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite),
    .sfrBitWrite(sfrBitWrite),
    .sfrWdata(sfrWdata),
    .sfrBitWdata(sfrBitWdata),
    .sfrRdata(sfrRdata),
    .sfrRbit(sfrRbit),
    .sfrHit(sfrHit),
    .extPinBEvent(extPinBEvent),
    .txFifoLevelEvent(txFifoLevelEvent),
    .watchdogEvent(watchdogEvent),
    .globalEnable(globalEnable),
    .irqRequest(irqRequest),
    .externalRequestFlags(externalRequestFlags),
    .radioRequestFlags(radioRequestFlags),
    .timerRequestFlags(timerRequestFlags)
);

// File: dv/irf_request_flags_bench.sv
// bench for the request flag registers
`timescale 1ns/1ns
module irf_request_flags_bench;
    logic clk = 1'h0, sys_rst = 1'h1, sfrWrite = 1'h0, sfrBitWrite = 1'h0, globalEnable = 1'h0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, extSourceEnable = 8'h00, radioSourceEnable = 8'h00, sfrRdata;
    logic [7:0] timerSourceEnable = 8'h8c, externalRequestFlags, radioRequestFlags, timerRequestFlags;
    logic [2:0] groupEnable = 3'h0;
    logic [23:0] fire = 24'h000000, evt, flags;
    logic sfrRbit, sfrHit, irqRequest;
    wire logic sfrBitWdata = sfrWdata[0]; // bit value rides on data bit 0
    int badCount = 0, nChecks = 0, cyc = 0;
    assign flags = {timerRequestFlags, radioRequestFlags, externalRequestFlags};
    irf_request_flags u_irf_request_flags (.*, .extPinAEvent(evt[0]), .extPinBEvent(evt[1]), .synthLockEvent(evt[8]),
        .txFifoLevelEvent(evt[9]), .rxFifoLevelEvent(evt[10]), .serialReadyEvent(evt[12]), .noiseRatioEvent(evt[13]),
        .signalingWordEvent(evt[14]), .watchdogEvent(evt[16]), .supplyDropEvent(evt[17]), .captureTimerBEvent(evt[20]),
        .captureTimerAEvent(evt[21]), .timeBaseEvent(evt[22]));
    irf_event_model u_irf_event_model (.clk, .fire, .evt);
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (cyc++ == 3000) stopTest(1);
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        nChecks++;
        badCount += (got !== exp);
        if (got !== exp) $display("unexpected %s exp %h got %h", what, exp, got);
    endtask : chk
    // one write on the register port, strobe held for exactly one rising edge
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = !b;
        sfrBitWrite = b;
        @(negedge clk);
        sfrWrite = 1'h0;
        sfrBitWrite = 1'h0;
    endtask : wr
    task automatic stopTest(input int extra);
        badCount += extra;
        $display("checks %0d bad %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stopTest
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'h0;
        wr(1'h0, 8'h12, 8'hff);
        #1 chk("unmapped", 24'h000000, {sfrHit, sfrRdata});
        for (int r = 0; r < 3; r++) wr(1'h0, 8'hd8 + 8'(16 * r), 8'hff);
        // clear one bit address at a time in all three registers
        for (int i = 0; i < 8; i++) begin
            for (int r = 0; r < 3; r++) wr(1'h1, 8'hd8 + 8'(16 * r + i), 8'h00);
            chk("flags", {3{8'hff << (i + 1)}} & 24'hffff03, flags);
        end
        // fire every position; unwired and spare positions must stay clear
        for (int p = 0; p < 24; p++) begin
            fire = 24'h000001 << p;
            @(negedge clk);
            fire = 24'h000000;
            @(negedge clk);
            chk("flags", ((24'h000002 << p) - 24'h000001) & 24'h737703, flags);
        end
        fire = 24'h000200;
        wr(1'h0, 8'he8, 8'h00);
        fire = 24'h000000;
        chk("flags", 24'h730203, flags);
        wr(1'h1, 8'hec, 8'h01);
        chk("flags", 24'h731203, flags);
        chk("bit read", 24'h000001, {23'h0, sfrRbit});
        wr(1'h0, 8'hf8, 8'h8c);
        chk("flags", 24'h8c1203, flags);
        chk("byte read", 24'h00018c, {15'h0, sfrHit, sfrRdata});
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            {globalEnable, groupEnable, radioSourceEnable[4]} = {k[2], {3{k[1]}}, k[0]};
            #1 chk("irq", {23'h0, k == 7}, {23'h0, irqRequest});
        end
        // mid-run reset with flags set and the global, group and radio bit 4 enables up: all clears
        @(negedge clk);
        sys_rst = 1'h1;
        @(negedge clk);
        sys_rst = 1'h0;
        chk("reset", 24'h000000, flags);
        chk("irq", 24'h000000, {23'h0, irqRequest});
        stopTest(0);
    end
endmodule : irf_request_flags_bench
